// ---- shared/sar_burst_pkg.sv ----
// constants, types and register layout for the burst accumulate control block
package sar_burst_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses on the AXI4-Lite bus)
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] CFG_OFS    = 8'h04;
  localparam logic [7:0] RESULT_OFS = 8'h08;
  localparam logic [7:0] STATUS_OFS = 8'h0C;

  // control register bit positions
  localparam int ENABLE_BIT = 0;
  localparam int BURST_BIT  = 1;
  localparam int LJST_BIT   = 2;
  localparam int DONE_BIT   = 3;
  localparam int BUSY_BIT   = 4;
  localparam int SRC_LSB    = 5;

  // values after reset
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [17:0] CFG_RESET  = 18'h0_0000;

  // convert start sources
  localparam logic [1:0] SRC_SW    = 2'h0;
  localparam logic [1:0] SRC_TIMER = 2'h1;
  localparam logic [1:0] SRC_PIN   = 2'h2;

  // tracking mode codes
  localparam logic [1:0] TM_POST = 2'h1;
  localparam logic [1:0] TM_PRE  = 2'h2;
  localparam logic [1:0] TM_DUAL = 2'h3;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_KHZ          = 25000;
  localparam int POWERUP_STEP_NS  = 320;
  localparam int POWERUP_STEP_CYC = (POWERUP_STEP_NS * CLK_KHZ + 999999) / 1000000;
  localparam int TRACK_EXTRA_CYC  = 2;
  localparam int CONV_SAR_TICKS   = 13;
  localparam int CONV_EXTRA_CYC   = 2;

  // sequencer states, one-hot
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_PWRUP = 4'b0010,
    ST_TRACK = 4'b0100,
    ST_CONV  = 4'b1000
  } state_t;

  // configuration register, packed from bit 17 down to bit 0
  typedef struct packed {
    logic [4:0] sarDivide;    // [17:13] SAR clock = clk / (value+1)
    logic [4:0] powerUpTime;  // [12:8]  units of POWERUP_STEP_CYC
    logic [3:0] trackTime;    // [7:4]   extra tracking cycles
    logic [1:0] trackMode;    // [3:2]
    logic [1:0] repeatSelect; // [1:0]   0:1 1:4 2:8 3:16
  } cfg_t;

endpackage

// ---- core/sar_clock_divider.sv ----
// enable-pulse divider producing the SAR conversion clock tick
`timescale 1ns/1ps
module sar_clock_divider
  import sar_burst_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       clear,
  input  wire logic [4:0] divide,
  output logic            tick
);

  logic [4:0] divCnt_q;

  // one tick every divide+1 cycles, restarted by clear
  assign tick = (divCnt_q == divide) && !clear;

  // ----------------------------------------------------------------
  // divide counter
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst || clear) begin
      divCnt_q <= 5'h00;
    end else if (divCnt_q == divide) begin
      divCnt_q <= 5'h00;
    end else begin
      divCnt_q <= divCnt_q + 5'h01;
    end
  end

endmodule

// ---- core/sar_burst_accumulate_control.sv ----
// burst sequencer, accumulator and result formatting for the 12-bit SAR converter
//
// Behaviour
// - burst wakes converter, accumulates 1/4/8/16 samples, returns to idle alone
// - burst operation only while burst_mode_enable is 1, else normal mode
// - burst with converter_enable 0 powers down after each series
// - burst with converter_enable 1 stays powered between series
// - start while powered down in burst: power up, wait power-up time, then track
// - start while powered in burst: track and convert with no wait
// - in burst one start runs repeat-count consecutive conversions
// - in normal mode one conversion per start, counted toward repeat count
// - done flag rises only when the full repeat count has accumulated
// - window compare strobes only after the full repeat count
// - repeat count one gives a 12-bit code refreshed every conversion
// - left_justify_select picks 0x0FFF or 0xFFF0 for full scale
// - unused result bits read as zero
// - repeat above one: result holds series sum, updated after last conversion
// - sums of 4/8/16 samples are unsigned right-justified
// - sequencing runs alone to finish a series without software
// - tracking lasts tracking_time_field plus two cycles
// - conversion lasts 13 SAR ticks plus two cycles
// - dual tracking with converter_enable 1 keeps tracking between conversions
`timescale 1ns/1ps
module sar_burst_accumulate_control
  import sar_burst_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        timerOverflow,
  input  wire logic        externalConvertStart,
  input  wire logic [11:0] sarCode,
  output logic             converterPowered,
  output logic             sampleTrack,
  output logic             conversionActive,
  output logic             windowCompareStrobe,
  output logic [15:0]      windowResult
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic        awHeld_q, wHeld_q;
  logic [7:0]  awAddr_q;
  logic [31:0] wData_q;
  logic [3:0]  wStrb_q;
  logic        wrEn;
  logic [31:0] wrMask, ctrlWord, cfgWord, ctrlNew, cfgNew;
  logic        converterEnable_q, burstModeEnable_q, leftJustifySelect_q;
  logic        conversionDoneFlag_q;
  logic [1:0]  startSource_q;
  cfg_t        cfg_q;
  logic        swStart_q, pinPrev_q, startEvent;
  state_t      state_q, state_d;
  logic [7:0]  cnt_q;
  logic [4:0]  sampleCnt_q, repeatLen;
  logic [15:0] accum_q, sum;
  logic        sarTick, divClear, convFinish, seriesEnd, trackEnd, pwrEnd;

  // ----------------------------------------------------------------
  // AXI4-Lite write channel: address and data taken in either order
  // ----------------------------------------------------------------
  assign wrEn   = awHeld_q && wHeld_q && !s_axi_bvalid;
  assign wrMask = {{8{wStrb_q[3]}}, {8{wStrb_q[2]}}, {8{wStrb_q[1]}}, {8{wStrb_q[0]}}};

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      awHeld_q      <= 1'b0;
      wHeld_q       <= 1'b0;
      awAddr_q      <= 8'h00;
      wData_q       <= 32'h0000_0000;
      wStrb_q       <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_q      <= 1'b1;
        awAddr_q      <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_q      <= 1'b1;
        wData_q      <= s_axi_wdata;
        wStrb_q      <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wrEn) begin
        awHeld_q     <= 1'b0;
        wHeld_q      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awAddr_q == CTRL_OFS || awAddr_q == CFG_OFS ||
                         awAddr_q == RESULT_OFS || awAddr_q == STATUS_OFS) ?
                        RESP_OKAY : RESP_DECERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel: answer one cycle after the address
  // ----------------------------------------------------------------
  assign ctrlWord = {25'h0, startSource_q, (state_q != ST_IDLE), conversionDoneFlag_q,
                     leftJustifySelect_q, burstModeEnable_q, converterEnable_q};
  assign cfgWord  = {14'h0, cfg_q};

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= RESP_OKAY;
      case (s_axi_araddr)
        CTRL_OFS:   s_axi_rdata <= ctrlWord;
        CFG_OFS:    s_axi_rdata <= cfgWord;
        RESULT_OFS: s_axi_rdata <= {16'h0000, windowResult}; // upper half reads zero
        STATUS_OFS: s_axi_rdata <= {23'h0, sampleCnt_q, state_q};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= RESP_DECERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // control and configuration registers
  // ----------------------------------------------------------------
  assign ctrlNew = (ctrlWord & ~wrMask) | (wData_q & wrMask);
  assign cfgNew  = (cfgWord & ~wrMask) | (wData_q & wrMask);

  // done flag: writing 0 clears, a series end in the same cycle wins
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      conversionDoneFlag_q <= CTRL_RESET[DONE_BIT];
    end else if (seriesEnd) begin
      conversionDoneFlag_q <= 1'b1;
    end else if (wrEn && awAddr_q == CTRL_OFS && !ctrlNew[DONE_BIT]) begin
      conversionDoneFlag_q <= 1'b0;
    end
  end

  // mode bits and configuration
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      converterEnable_q   <= CTRL_RESET[ENABLE_BIT];
      burstModeEnable_q   <= CTRL_RESET[BURST_BIT];
      leftJustifySelect_q <= CTRL_RESET[LJST_BIT];
      startSource_q       <= CTRL_RESET[SRC_LSB +: 2];
      cfg_q               <= CFG_RESET;
    end else if (wrEn && awAddr_q == CTRL_OFS) begin
      converterEnable_q   <= ctrlNew[ENABLE_BIT];
      burstModeEnable_q   <= ctrlNew[BURST_BIT];
      leftJustifySelect_q <= ctrlNew[LJST_BIT];
      startSource_q       <= ctrlNew[SRC_LSB +: 2];
    end else if (wrEn && awAddr_q == CFG_OFS) begin
      cfg_q <= cfgNew[17:0];
    end
  end

  // ----------------------------------------------------------------
  // convert start sources
  // ----------------------------------------------------------------
  // software start is a pulse from writing 1 to the busy bit
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      swStart_q <= 1'b0;
      pinPrev_q <= 1'b0;
    end else begin
      swStart_q <= wrEn && awAddr_q == CTRL_OFS && wStrb_q[0] && wData_q[BUSY_BIT];
      pinPrev_q <= externalConvertStart;
    end
  end

  // starts that arrive while a conversion runs are dropped
  always_comb begin
    case (startSource_q)
      SRC_SW:    startEvent = swStart_q;
      SRC_TIMER: startEvent = timerOverflow;
      SRC_PIN:   startEvent = externalConvertStart && !pinPrev_q;
      default:   startEvent = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_comb begin
    case (cfg_q.repeatSelect)
      2'h0:    repeatLen = 5'd1;
      2'h1:    repeatLen = 5'd4;
      2'h2:    repeatLen = 5'd8;
      default: repeatLen = 5'd16;
    endcase
  end

  assign pwrEnd     = state_q == ST_PWRUP &&
                      cnt_q + 8'h01 >= 8'(cfg_q.powerUpTime) * 8'(POWERUP_STEP_CYC);
  assign trackEnd   = state_q == ST_TRACK &&
                      cnt_q == 8'(cfg_q.trackTime) + 8'(TRACK_EXTRA_CYC - 1);
  assign divClear   = state_q == ST_CONV && cnt_q == 8'h00;
  assign convFinish = state_q == ST_CONV && cnt_q == 8'(CONV_SAR_TICKS + 1);
  assign seriesEnd  = convFinish && (sampleCnt_q + 5'h01 == repeatLen);

  sar_clock_divider u_sarDiv (
    .clk_sys (clk_sys),
    .rst     (rst),
    .clear   (divClear),
    .divide  (cfg_q.sarDivide),
    .tick    (sarTick)
  );

  // next state: burst chains conversions, normal mode stops after one
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (startEvent && burstModeEnable_q) begin
          state_d = converterPowered ? ST_TRACK : ST_PWRUP;
        end else if (startEvent && converterEnable_q) begin
          state_d = (cfg_q.trackMode == TM_PRE) ? ST_CONV : ST_TRACK;
        end
      end
      ST_PWRUP: if (pwrEnd) state_d = ST_TRACK;
      ST_TRACK: if (trackEnd) state_d = ST_CONV;
      ST_CONV: begin
        if (convFinish) begin
          state_d = (burstModeEnable_q && !seriesEnd) ? ST_TRACK : ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d; // a series runs to its end with no software step
    end
  end

  // phase counter, restarted on every state change
  always_ff @(posedge clk_sys) begin
    if (rst || state_d != state_q) begin
      cnt_q <= 8'h00;
    end else if (state_q == ST_CONV) begin
      if (cnt_q == 8'h00 || (sarTick && cnt_q <= 8'(CONV_SAR_TICKS))) begin
        cnt_q <= cnt_q + 8'h01;
      end
    end else if (state_q != ST_IDLE) begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // accumulator and result
  // ----------------------------------------------------------------
  // the first sample of a series replaces the old sum
  assign sum = (sampleCnt_q == 5'h00 ? 16'h0000 : accum_q) + {4'h0, sarCode};

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      accum_q     <= 16'h0000;
      sampleCnt_q <= 5'h00;
    end else if (convFinish) begin
      accum_q     <= sum;
      sampleCnt_q <= seriesEnd ? 5'h00 : sampleCnt_q + 5'h01;
    end
  end

  // result only moves at the end of a series; left justify is for single samples only
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      windowResult <= 16'h0000;
    end else if (seriesEnd && repeatLen == 5'd1) begin
      windowResult <= leftJustifySelect_q ? {sarCode, 4'h0} : {4'h0, sarCode};
    end else if (seriesEnd) begin
      windowResult <= sum;
    end
  end

  // ----------------------------------------------------------------
  // analog-facing outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      converterPowered    <= 1'b0;
      sampleTrack         <= 1'b0;
      conversionActive    <= 1'b0;
      windowCompareStrobe <= 1'b0;
    end else begin
      converterPowered    <= converterEnable_q ||
                             (burstModeEnable_q && state_d != ST_IDLE);
      sampleTrack         <= state_d == ST_TRACK ||
                             (state_d == ST_IDLE && converterEnable_q &&
                              cfg_q.trackMode[1]);
      conversionActive    <= state_d == ST_CONV;
      windowCompareStrobe <= seriesEnd;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [8:0] trkLen_q, convLen_q;

  always_ff @(posedge clk_sys) begin
    if (rst || state_q != ST_TRACK) trkLen_q <= 9'h000;
    else trkLen_q <= trkLen_q + 9'h001;
    if (rst || state_q != ST_CONV) convLen_q <= 9'h000;
    else convLen_q <= convLen_q + 9'h001;
  end

  AST_TRACK_LEN: assert property (@(posedge clk_sys) disable iff (rst)
    trackEnd |-> trkLen_q == 9'(cfg_q.trackTime) + 9'd1)
    else $error("tracking length wrong");
  AST_CONV_LEN: assert property (@(posedge clk_sys) disable iff (rst)
    convFinish && cfg_q.trackMode != TM_PRE |->
      convLen_q == 9'd13 * (9'(cfg_q.sarDivide) + 9'd1) + 9'd1)
    else $error("conversion length wrong");
  AST_DONE_AFTER_SERIES: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(conversionDoneFlag_q) |-> $past(convFinish) && $past(sampleCnt_q) == repeatLen - 5'd1)
    else $error("done flag before full series");
  AST_WAKE_WAIT: assert property (@(posedge clk_sys) disable iff (rst)
    state_q == ST_IDLE && startEvent && burstModeEnable_q && !converterPowered
      |=> state_q == ST_PWRUP)
    else $error("no power-up wait");
  AST_NO_WAIT: assert property (@(posedge clk_sys) disable iff (rst)
    state_q == ST_IDLE && startEvent && burstModeEnable_q && converterPowered
      |=> state_q == ST_TRACK)
    else $error("needless power-up wait");
  AST_POWER_DOWN: assert property (@(posedge clk_sys) disable iff (rst)
    seriesEnd && burstModeEnable_q && !converterEnable_q |=> !converterPowered)
    else $error("stayed powered after burst");
  AST_STAY_POWERED: assert property (@(posedge clk_sys) disable iff (rst)
    converterEnable_q && $past(converterEnable_q) |-> converterPowered)
    else $error("powered down while enabled");
  AST_BURST_CHAIN: assert property (@(posedge clk_sys) disable iff (rst)
    convFinish && burstModeEnable_q && !seriesEnd |=> state_q == ST_TRACK ##1 sampleTrack)
    else $error("burst did not continue");
  AST_NORMAL_SINGLE: assert property (@(posedge clk_sys) disable iff (rst)
    convFinish && !burstModeEnable_q |=> state_q == ST_IDLE)
    else $error("normal mode ran on");
  AST_SINGLE_FORMAT: assert property (@(posedge clk_sys) disable iff (rst)
    windowCompareStrobe && repeatLen == 5'd1 |->
      (leftJustifySelect_q ? windowResult[3:0] == 4'h0 : windowResult[15:12] == 4'h0))
    else $error("unused result bits not zero");

  COV_BURST_FROM_DOWN: cover property (@(posedge clk_sys) disable iff (rst)
    state_q == ST_PWRUP ##1 state_q == ST_TRACK);
  COV_BURST_16: cover property (@(posedge clk_sys) disable iff (rst)
    seriesEnd && burstModeEnable_q && repeatLen == 5'd16);
  COV_NORMAL_4: cover property (@(posedge clk_sys) disable iff (rst)
    seriesEnd && !burstModeEnable_q && repeatLen == 5'd4);

endmodule

// ---- verification/test_sar_burst_accumulate_control.sv ----
// self-checking register-level bench for the burst accumulate control block
`timescale 1ns/1ps
module test_sar_burst_accumulate_control
  import sar_burst_pkg::*;
;
  // ----------------------------------------------------------------
  // clock, reset and design hookup
  // ----------------------------------------------------------------
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic        timerOverflow, externalConvertStart;
  logic [11:0] sarCode;
  logic        converterPowered, sampleTrack, conversionActive, windowCompareStrobe;
  logic [15:0] windowResult;
  int          err_total, checks, strobeCount, convCount, trkRun, trkLen, convRun, convLen;

  always #20 clk_sys = ~clk_sys;

  sar_burst_accumulate_control DUT (
    .clk_sys, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .timerOverflow, .externalConvertStart,
    .sarCode, .converterPowered, .sampleTrack, .conversionActive,
    .windowCompareStrobe, .windowResult
  );

  // pulse monitor: run lengths of track and convert phases, series strobes
  always @(posedge clk_sys) begin
    if (windowCompareStrobe === 1'b1) strobeCount++;
    if (sampleTrack === 1'b1) trkRun++;
    else if (trkRun != 0) begin
      trkLen = trkRun;
      trkRun = 0;
    end
    if (conversionActive === 1'b1) convRun++;
    else if (convRun != 0) begin
      convLen = convRun;
      convRun = 0;
      convCount++;
    end
  end

  // ----------------------------------------------------------------
  // bus tasks and helpers
  // ----------------------------------------------------------------
  // values are read just after the edge, so they are the ones the edge sampled
  task automatic axiWr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n = 0;
    s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
    r = 2'h2;
    while (n < 100) begin
      @(posedge clk_sys);
      n++;
      if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        n = 100;
      end
    end
    @(posedge clk_sys); // a spare edge so no signal is driven twice in one step
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n = 0;
    s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
    d = 32'hDEAD_BEEF;
    r = 2'h2;
    while (n < 100) begin
      @(posedge clk_sys);
      n++;
      if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        n = 100;
      end
    end
    @(posedge clk_sys);
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic waitPin(ref logic sig, input logic lvl, input int lim, output int n);
    n = 0;
    while (sig !== lvl && n < lim) begin
      @(posedge clk_sys);
      n++;
    end
  endtask

  // control word: done bit written 0 so each write also clears the flag
  function automatic logic [31:0] ctl(input logic en, bu, lj, input logic [1:0] src,
                                      input logic go);
    return {25'h0, src, go, 1'b0, lj, bu, en};
  endfunction

  function automatic logic [31:0] cfgw(input logic [4:0] dv, pw, input logic [3:0] tk,
                                       input logic [1:0] tm, rp);
    return {14'h0, dv, pw, tk, tm, rp};
  endfunction

  task automatic results();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    logic [15:0] sum;
    int          n, c0, s0;
    s_axi_awaddr = 8'h00; s_axi_araddr = 8'h00; s_axi_wdata = 32'h0; s_axi_wstrb = 4'h0;
    s_axi_awvalid = 1'b0; s_axi_wvalid = 1'b0; s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0; s_axi_rready = 1'b0;
    timerOverflow = 1'b0; externalConvertStart = 1'b0; sarCode = 12'h000;
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    rd(CTRL_OFS, d, r); check("ctrl reset", d, CTRL_RESET);
    rd(CFG_OFS, d, r); check("cfg reset", d, {14'h0, CFG_RESET});
    rd(STATUS_OFS, d, r); check("idle state", 32'(d[3:0]), 32'(ST_IDLE));
    rd(8'h10, d, r); check("unmapped read", {d[29:0], r}, {30'h0, RESP_DECERR});
    axiWr(8'h10, 32'h0000_00FF, r); check("unmapped write", 32'(r), 32'(RESP_DECERR));
    $display("test reset done");
    // single conversions, both justifications, full scale code
    axiWr(CFG_OFS, cfgw(5'h0, 5'h0, 4'h0, TM_POST, 2'h0), r);
    sarCode <= 12'hFFF;
    for (int lj = 0; lj < 2; lj++) begin
      axiWr(CTRL_OFS, ctl(1'b1, 1'b0, lj[0], SRC_SW, 1'b1), r);
      waitPin(windowCompareStrobe, 1'b1, 3000, n);
      repeat (2) @(posedge clk_sys);
      rd(RESULT_OFS, d, r); check("single result", d, lj[0] ? 32'hFFF0 : 32'h0FFF);
      check("window result", 32'(windowResult), lj[0] ? 32'hFFF0 : 32'h0FFF);
    end
    $display("test justify done");
    // normal mode, repeat 4: one conversion per start, flag only after the fourth
    axiWr(CFG_OFS, cfgw(5'h0, 5'h0, 4'h1, TM_POST, 2'h1), r);
    sum = 16'h0; c0 = convCount; s0 = strobeCount;
    for (int i = 0; i < 4; i++) begin
      sarCode <= 12'h123 + 12'(i) * 12'h211;
      sum = sum + 16'(12'h123 + 12'(i) * 12'h211);
      axiWr(CTRL_OFS, ctl(1'b1, 1'b0, 1'b0, SRC_SW, 1'b1), r);
      waitPin(conversionActive, 1'b1, 200, n);
      waitPin(conversionActive, 1'b0, 200, n);
      repeat (3) @(posedge clk_sys);
      check("normal conversions", 32'(convCount - c0), 32'(i + 1));
      rd(CTRL_OFS, d, r); check("done flag", 32'(d[DONE_BIT]), (i == 3) ? 32'h1 : 32'h0);
    end
    check("normal strobes", 32'(strobeCount - s0), 32'h1);
    rd(RESULT_OFS, d, r); check("normal sum", d, 32'(sum));
    axiWr(CTRL_OFS, ctl(1'b1, 1'b0, 1'b0, SRC_SW, 1'b0), r);
    rd(CTRL_OFS, d, r); check("done cleared", 32'(d[DONE_BIT]), 32'h0);
    $display("test normal repeat done");
    // burst with converter_enable 0, repeat 4, 8 and 16; only the 8 and 16 runs start from power down
    sarCode <= 12'hFFF;
    for (int k = 1; k < 4; k++) begin
      axiWr(CFG_OFS, cfgw(5'h0, 5'h1, 4'h0, TM_POST, k[1:0]), r);
      c0 = convCount; s0 = strobeCount;
      axiWr(CTRL_OFS, ctl(1'b0, 1'b1, 1'b0, SRC_SW, 1'b1), r);
      waitPin(windowCompareStrobe, 1'b1, 3000, n);
      repeat (4) @(posedge clk_sys);
      rd(RESULT_OFS, d, r); check("burst sum", d, (k == 1) ? 32'h3FFC : (k == 2) ? 32'h7FF8 : 32'hFFF0);
      check("burst conversions", 32'(convCount - c0), 32'(4 << (k - 1)));
      check("burst strobes", 32'(strobeCount - s0), 32'h1);
      check("powered down", 32'(converterPowered), 32'h0);
    end
    $display("test burst table done");
    // timer start from power down in dual tracking: power-up wait first
    axiWr(CFG_OFS, cfgw(5'h0, 5'h2, 4'h0, TM_DUAL, 2'h0), r);
    axiWr(CTRL_OFS, ctl(1'b0, 1'b1, 1'b0, SRC_TIMER, 1'b0), r);
    timerOverflow <= 1'b1;
    @(posedge clk_sys);
    timerOverflow <= 1'b0;
    waitPin(sampleTrack, 1'b1, 300, n);
    check("power-up wait", 32'(n >= 2 * POWERUP_STEP_CYC && n < 300), 32'h1);
    waitPin(windowCompareStrobe, 1'b1, 3000, n);
    check("power-up series", 32'(n < 3000), 32'h1);
    $display("test power-up done");
    // pin start while powered: no wait, phase lengths, stays powered
    axiWr(CFG_OFS, cfgw(5'h1, 5'h4, 4'h3, TM_POST, 2'h1), r);
    axiWr(CTRL_OFS, ctl(1'b1, 1'b1, 1'b0, SRC_PIN, 1'b0), r);
    repeat (3) @(posedge clk_sys);
    externalConvertStart <= 1'b1;
    waitPin(sampleTrack, 1'b1, 300, n);
    check("no power-up wait", 32'(n <= 4), 32'h1);
    waitPin(windowCompareStrobe, 1'b1, 3000, n);
    externalConvertStart <= 1'b0;
    repeat (4) @(posedge clk_sys);
    check("track length", 32'(trkLen), 32'(3 + TRACK_EXTRA_CYC));
    check("convert length", 32'(convLen), 32'(CONV_SAR_TICKS * 2 + CONV_EXTRA_CYC));
    check("stays powered", 32'(converterPowered), 32'h1);
    check("pin sum", 32'(windowResult), 32'h3FFC);
    axiWr(CFG_OFS, cfgw(5'h1, 5'h4, 4'h3, TM_DUAL, 2'h1), r);
    repeat (3) @(posedge clk_sys);
    check("idle tracking", 32'(sampleTrack), 32'h1);
    $display("test powered burst done");
    // pre-tracking in normal mode: conversion starts at once, no track phase
    axiWr(CFG_OFS, cfgw(5'h0, 5'h0, 4'h3, TM_PRE, 2'h0), r);
    c0 = convCount;
    axiWr(CTRL_OFS, ctl(1'b1, 1'b0, 1'b0, SRC_SW, 1'b1), r);
    waitPin(windowCompareStrobe, 1'b1, 3000, n);
    repeat (3) @(posedge clk_sys);
    check("pre conversions", 32'(convCount - c0), 32'h1);
    check("pre length", 32'(convLen), 32'(CONV_SAR_TICKS + CONV_EXTRA_CYC));
    check("pre result", 32'(windowResult), 32'h0FFF);
    $display("test pre-tracking done");
    results();
  end

  // watchdog: the whole sequence needs well under ten thousand cycles
  initial begin
    repeat (40000) @(posedge clk_sys);
    err_total++;
    results();
  end
endmodule
